// >>> rtl/tad_pkg.sv
// Shared constants for the transient acceleration detector
package tad_pkg;
    localparam logic [7:0] ADDR_CFG = 8'h1D;
    localparam logic [7:0] ADDR_SRC = 8'h1E;
    localparam logic [7:0] ADDR_THR = 8'h1F;
    localparam logic [7:0] ADDR_CNT = 8'h20;
    localparam logic [7:0] RST_THR = 8'h00;
    localparam logic [7:0] RST_CNT = 8'h00;
    localparam logic [4:0] RST_CFG = 5'h00;
    localparam logic [6:0] RST_SRC = 7'h00;
    localparam int CFG_BYP = 0;
    localparam int CFG_XEN = 1;
    localparam int CFG_LATCH = 4;
    localparam int SRC_ACTIVE = 6;
    localparam int THR_DBM = 7;
    localparam int THR_SHIFT = 4;
    localparam logic [6:0] LN_THR_MAX = 7'h40;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STEP_BASE_NS = 1250000;
    localparam int STEP_BASE_CYCLES = STEP_BASE_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        TAD_NORMAL = 2'b00,
        TAD_LOWNOISE = 2'b01,
        TAD_HIRES = 2'b10,
        TAD_LOWPOWER = 2'b11
    } tad_mode_t;
endpackage

// >>> rtl/tad_axis.sv
// Per-axis debounce counter of the transient detector
`timescale 1ns/10ps
`default_nettype none
module tad_axis (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic step,
    input wire logic exceed,
    input wire logic negative,
    input wire logic dbnc_clear_mode,
    input wire logic [7:0] count_lim,
    output logic hit,
    output logic hit_neg
);
    typedef struct packed {
        logic [7:0] cnt;
        logic hit;
        logic neg;
    } tad_axis_state_t;

    tad_axis_state_t st_reg;
    tad_axis_state_t st_next;
    logic [7:0] up;

    always_comb begin
        st_next = st_reg;
        st_next.hit = 1'b0;
        up = (st_reg.cnt < count_lim) ? st_reg.cnt + 8'h01 : count_lim;
        if (step) begin
            if (exceed) begin
                st_next.cnt = up;
                if (up == count_lim) begin
                    st_next.hit = 1'b1;
                    st_next.neg = negative;
                end
            end else if (dbnc_clear_mode) begin
                st_next.cnt = 8'h00;
            end else if (st_reg.cnt != 8'h00) begin
                st_next.cnt = st_reg.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hit = st_reg.hit;
    assign hit_neg = st_reg.neg;

    AST_CNT_CAP: assert property (@(posedge clk) disable iff (!arst_n)
        step && exceed && st_reg.cnt >= count_lim |=> st_reg.cnt == $past(count_lim) && hit)
        else $error("debounce count passed its limit");
    AST_CLR_MODE: assert property (@(posedge clk) disable iff (!arst_n)
        step && !exceed && dbnc_clear_mode |=> st_reg.cnt == 8'h00 && !hit)
        else $error("clear mode did not clear counter");
    AST_DEC_MODE: assert property (@(posedge clk) disable iff (!arst_n)
        step && !exceed && !dbnc_clear_mode && st_reg.cnt != 8'h00
        |=> st_reg.cnt == $past(st_reg.cnt) - 8'h01)
        else $error("decrement mode did not step down");
    AST_QUALIFY: assert property (@(posedge clk) disable iff (!arst_n)
        hit |-> $past(step) && $past(exceed) && st_reg.cnt == $past(count_lim))
        else $error("hit without full debounce");
endmodule
`default_nettype wire

// >>> rtl/tad_top.sv
// Transient acceleration detector with its register slice
`timescale 1ns/10ps
`default_nettype none
module tad_top #(
    parameter int STEP_BASE_CYCLES = tad_pkg::STEP_BASE_CYCLES,
    parameter int SAMPLE_W = 12
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [SAMPLE_W-1:0] hpf_sample_x,
    input wire logic [SAMPLE_W-1:0] hpf_sample_y,
    input wire logic [SAMPLE_W-1:0] hpf_sample_z,
    input wire logic [SAMPLE_W-1:0] raw_sample_x,
    input wire logic [SAMPLE_W-1:0] raw_sample_y,
    input wire logic [SAMPLE_W-1:0] raw_sample_z,
    input wire logic [2:0] output_sample_rate,
    input wire logic [1:0] oversample_mode,
    input wire logic low_noise,
    input wire logic int_enable,
    output logic transient_irq,
    output logic event_active_flag
);
    typedef struct packed {
        logic [7:0] thr;
        logic [7:0] cnt;
        logic [4:0] cfg;
        logic [6:0] src;
        logic [7:0] rdata;
        logic irq;
        logic [23:0] base;
        logic [7:0] pre;
        logic step;
    } tad_state_t;

    tad_state_t st_reg;
    tad_state_t st_next;
    logic [SAMPLE_W-1:0] hpf [3];
    logic [SAMPLE_W-1:0] raw [3];
    logic [SAMPLE_W-1:0] sel [3];
    logic [SAMPLE_W-1:0] mag [3];
    logic [6:0] thr_eff;
    logic [SAMPLE_W-1:0] thr_lsb;
    logic [2:0] exceed;
    logic [2:0] hit;
    logic [2:0] hit_neg;
    logic rd_src;
    logic frozen;
    logic base_tick;

    // Time step multiple of 1.25 ms, indexed by rate 800 Hz down to 1.56 Hz
    function automatic logic [7:0] tad_step_mult(input logic [2:0] rate_sel,
        input logic [1:0] m);
        logic [7:0] v;
        v = 8'h01 << rate_sel;
        case (tad_pkg::tad_mode_t'(m))
            tad_pkg::TAD_NORMAL: v = (rate_sel > 3'h4) ? 8'h10 : v;
            tad_pkg::TAD_LOWNOISE: v = (rate_sel > 3'h4) ? 8'h40 : v;
            tad_pkg::TAD_HIRES: v = (rate_sel > 3'h1) ? 8'h02 : v;
            tad_pkg::TAD_LOWPOWER: begin
                v = (rate_sel == 3'h5) ? 8'h40 : v;
                v = (rate_sel > 3'h5) ? 8'h80 : v;
            end
            default: v = 8'h01;
        endcase
        return v;
    endfunction

    assign hpf[0] = hpf_sample_x;
    assign hpf[1] = hpf_sample_y;
    assign hpf[2] = hpf_sample_z;
    assign raw[0] = raw_sample_x;
    assign raw[1] = raw_sample_y;
    assign raw[2] = raw_sample_z;

    assign thr_eff = (low_noise && st_reg.thr[6:0] > tad_pkg::LN_THR_MAX)
        ? tad_pkg::LN_THR_MAX : st_reg.thr[6:0];
    // one count is 16 LSB at 8g scale
    assign thr_lsb = SAMPLE_W'(thr_eff) << tad_pkg::THR_SHIFT;

    genvar a;
    generate
        for (a = 0; a < 3; a++) begin : g_axis
            assign sel[a] = st_reg.cfg[tad_pkg::CFG_BYP] ? raw[a] : hpf[a];
            assign mag[a] = sel[a][SAMPLE_W-1] ? SAMPLE_W'(-sel[a]) : sel[a];
            assign exceed[a] = st_reg.cfg[tad_pkg::CFG_XEN + a] && (mag[a] > thr_lsb);
            tad_axis tad_axis_i (
                .clk(clk),
                .arst_n(arst_n),
                .step(st_reg.step),
                .exceed(exceed[a]),
                .negative(sel[a][SAMPLE_W-1]),
                .dbnc_clear_mode(st_reg.thr[tad_pkg::THR_DBM]),
                .count_lim(st_reg.cnt),
                .hit(hit[a]),
                .hit_neg(hit_neg[a])
            );
        end
    endgenerate

    assign rd_src = reg_rd && reg_addr == tad_pkg::ADDR_SRC;
    assign frozen = st_reg.cfg[tad_pkg::CFG_LATCH] && st_reg.src[tad_pkg::SRC_ACTIVE] && !rd_src;
    assign base_tick = st_reg.base == 24'(STEP_BASE_CYCLES - 1);

    always_comb begin
        st_next = st_reg;
        st_next.step = 1'b0;
        st_next.base = base_tick ? 24'h000000 : st_reg.base + 24'h000001;
        if (base_tick) begin
            if (st_reg.pre + 8'h01 >= tad_step_mult(output_sample_rate, oversample_mode)) begin
                st_next.pre = 8'h00;
                st_next.step = 1'b1;
            end else begin
                st_next.pre = st_reg.pre + 8'h01;
            end
        end
        if (reg_wr) begin
            case (reg_addr)
                tad_pkg::ADDR_CFG: st_next.cfg = reg_wdata[4:0];
                tad_pkg::ADDR_THR: st_next.thr = reg_wdata;
                tad_pkg::ADDR_CNT: st_next.cnt = reg_wdata;
                default: st_next.cfg = st_reg.cfg;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                tad_pkg::ADDR_CFG: st_next.rdata = {3'h0, st_reg.cfg};
                tad_pkg::ADDR_SRC: st_next.rdata = {1'b0, st_reg.src};
                tad_pkg::ADDR_THR: st_next.rdata = st_reg.thr;
                tad_pkg::ADDR_CNT: st_next.rdata = st_reg.cnt;
                default: st_next.rdata = 8'h00;
            endcase
        end
        if (rd_src) begin
            st_next.src = tad_pkg::RST_SRC;
        end
        // set wins over the read clear, polarity, no clear
        for (int i = 0; i < 3; i++) begin
            if (hit[i] && !frozen) begin
                st_next.src[2*i+1] = 1'b1;
                st_next.src[2*i] = hit_neg[i];
            end
        end
        st_next.src[tad_pkg::SRC_ACTIVE] = st_next.src[1] | st_next.src[3] | st_next.src[5];
        st_next.irq = st_next.src[tad_pkg::SRC_ACTIVE] && int_enable;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign transient_irq = st_reg.irq;
    assign event_active_flag = st_reg.src[tad_pkg::SRC_ACTIVE];

    sequence s_src_read;
        reg_rd && reg_addr == tad_pkg::ADDR_SRC;
    endsequence
    sequence s_x_event;
        hit[0] && !frozen;
    endsequence

    AST_EA_MATCH: assert property (@(posedge clk) disable iff (!arst_n)
        st_reg.src[6] == (st_reg.src[1] || st_reg.src[3] || st_reg.src[5]))
        else $error("event active disagrees with axis flags");
    AST_READ_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
        s_src_read ##0 (hit == 3'h0) |=> st_reg.src == 7'h00)
        else $error("source read did not clear");
    AST_FREEZE: assert property (@(posedge clk) disable iff (!arst_n)
        st_reg.cfg[4] && st_reg.src[6] && !rd_src |=> $stable(st_reg.src))
        else $error("latched source changed");
    AST_X_SET: assert property (@(posedge clk) disable iff (!arst_n)
        s_x_event |=> st_reg.src[1] && st_reg.src[0] == $past(hit_neg[0]))
        else $error("x event flag or polarity missed");
    AST_NO_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
        st_reg.src[3] && !rd_src |=> st_reg.src[3])
        else $error("axis flag cleared without read");
    AST_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 transient_irq == (st_reg.src[6] && $past(int_enable)))
        else $error("interrupt does not follow enable and event");
    AST_THR_WR: assert property (@(posedge clk) disable iff (!arst_n)
        reg_wr && reg_addr == tad_pkg::ADDR_THR |=> st_reg.thr == $past(reg_wdata))
        else $error("threshold write lost");
    AST_AXIS_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        !st_reg.cfg[1] |-> !exceed[0])
        else $error("disabled axis detected");
    AST_STEP_TICK: assert property (@(posedge clk) disable iff (!arst_n)
        st_reg.step |-> $past(base_tick))
        else $error("debounce step off the base tick");
endmodule
`default_nettype wire

// >>> verification/tad_host.sv
// Host model that reaches the detector registers
`timescale 1ns/10ps
`default_nettype none
module tad_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Data launched at the strobe edge is taken at the following edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> verification/transient_accel_detector_bench.sv
// Self-checking bench of the transient detector
`timescale 1ns/10ps
`default_nettype none
module transient_accel_detector_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic reg_wr, reg_rd;
    logic [11:0] hx = 12'h000, hy = 12'h000, hz = 12'h000;
    logic [11:0] rx = 12'h000, ry = 12'h000, rz = 12'h000;
    logic [2:0] rate = 3'h0;
    logic [1:0] mode = 2'h0;
    logic low_noise = 1'b0;
    logic int_enable = 1'b0;
    logic transient_irq, event_active_flag;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Short step base keeps the debounce periods to a few cycles
    tad_top #(.STEP_BASE_CYCLES(4), .SAMPLE_W(12)) tad_top_i (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .hpf_sample_x(hx), .hpf_sample_y(hy), .hpf_sample_z(hz),
        .raw_sample_x(rx), .raw_sample_y(ry), .raw_sample_z(rz), .output_sample_rate(rate),
        .oversample_mode(mode), .low_noise(low_noise), .int_enable(int_enable),
        .transient_irq(transient_irq), .event_active_flag(event_active_flag));
    tad_host tad_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        tad_host_i.rd_reg(a, rd_val);
        check($sformatf("reg %h", a), rd_val, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tad_host_i.wr_reg(a, d);
    endtask
    // Drives one path, then idles six cycles, long enough for a quiet step at rate 0
    task automatic fire(input logic [11:0] x, y, z, input logic raw, input int n);
        @(posedge clk);
        {hx, hy, hz} <= raw ? 36'h0 : {x, y, z};
        {rx, ry, rz} <= raw ? {x, y, z} : 36'h0;
        repeat (n) @(posedge clk);
        {hx, hy, hz, rx, ry, rz} <= 72'h0;
        repeat (6) @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 'h1D; a <= 'h20; a++) rd_chk(8'(a), 8'h00);
        rd_chk(8'h30, 8'h00);
        wr(8'h1F, 8'hFF);
        rd_chk(8'h1F, 8'hFF);
        wr(8'h20, 8'hA5);
        rd_chk(8'h20, 8'hA5);
        wr(8'h1E, 8'hFF);
        rd_chk(8'h1E, 8'h00);
        wr(8'h1F, 8'h02);
        wr(8'h20, 8'h00);
        wr(8'h1D, 8'h02);
        int_enable <= 1'b1;
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        check("irq", {7'h0, transient_irq}, 8'h01);
        check("active", {7'h0, event_active_flag}, 8'h01);
        rd_chk(8'h1E, 8'h42);
        repeat (2) @(posedge clk);
        check("irq clr", {7'h0, transient_irq}, 8'h00);
        rd_chk(8'h1E, 8'h00);
        int_enable <= 1'b0;
        wr(8'h1D, 8'h0E);
        fire(12'h000, 12'hFD8, 12'h000, 1'b0, 16);
        check("irq off", {7'h0, transient_irq}, 8'h00);
        rd_chk(8'h1E, 8'h4C);
        fire(12'h020, 12'hFE0, 12'h020, 1'b0, 16);
        rd_chk(8'h1E, 8'h00);
        wr(8'h1D, 8'h06);
        fire(12'h000, 12'h000, 12'h7FF, 1'b0, 16);
        rd_chk(8'h1E, 8'h00);
        wr(8'h1D, 8'h0B);
        fire(12'h000, 12'h000, 12'hFD8, 1'b1, 16);
        rd_chk(8'h1E, 8'h70);
        wr(8'h1D, 8'h08);
        fire(12'h000, 12'h000, 12'hFD8, 1'b1, 16);
        rd_chk(8'h1E, 8'h00);
        wr(8'h1F, 8'h50);
        wr(8'h1D, 8'h02);
        fire(12'h44C, 12'h000, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h00);
        low_noise <= 1'b1;
        fire(12'h44C, 12'h000, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h42);
        low_noise <= 1'b0;
        wr(8'h1F, 8'h02);
        wr(8'h20, 8'h05);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h00);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 40);
        rd_chk(8'h1E, 8'h42);
        // Clearing mode loses the partial count across a quiet step
        wr(8'h1F, 8'h82);
        repeat (8) @(posedge clk);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h00);
        wr(8'h1F, 8'h02);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h42);
        wr(8'h1F, 8'h82);
        wr(8'h20, 8'h03);
        repeat (8) @(posedge clk);
        rate <= 3'h3;
        fire(12'h028, 12'h000, 12'h000, 1'b0, 40);
        rd_chk(8'h1E, 8'h00);
        mode <= 2'h2;
        fire(12'h028, 12'h000, 12'h000, 1'b0, 40);
        rd_chk(8'h1E, 8'h42);
        // Slow steps keep a long burst under the count of three
        for (int m = 1; m <= 3; m += 2) begin
            rate <= 3'h0;
            mode <= 2'h0;
            repeat (8) @(posedge clk);
            rate <= 3'(m + 4);
            mode <= 2'(m);
            fire(12'h028, 12'h000, 12'h000, 1'b0, 250 * m + 250);
            rd_chk(8'h1E, 8'h00);
        end
        rate <= 3'h0;
        mode <= 2'h0;
        wr(8'h1F, 8'h02);
        wr(8'h20, 8'h00);
        wr(8'h1D, 8'h16);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        fire(12'h000, 12'hFD8, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h42);
        wr(8'h1D, 8'h06);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        fire(12'h000, 12'hFD8, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h4E);
        fire(12'h028, 12'h000, 12'h000, 1'b0, 16);
        fire(12'hFD8, 12'h000, 12'h000, 1'b0, 16);
        rd_chk(8'h1E, 8'h43);
        close_out();
    end
endmodule
`default_nettype wire
